/* File: rtl/encoder_calib_regs.svh */
// register offsets, command codes, status codes and timing for the command sequencer
`ifndef ENCODER_CALIB_REGS_SVH
`define ENCODER_CALIB_REGS_SVH

`define BANK_SELECT_ADDR 8'h40
`define DEVICE_MODE_ADDR 8'h6A
`define MODE_UNLOCK_PASSWORD_ADDR 8'h6B
`define PAGED_WINDOW_LIMIT 8'h40

`define CALIBRATION_COMMAND_ADDR 6'h00
`define CALIBRATION_STATUS_ADDR 6'h01
`define DATA_WRITE_COMMAND_ADDR 6'h1A
`define DATA_WRITE_STATUS_ADDR 6'h1B

`define UNLOCK_PASSWORD 8'h2A
`define MODE_NORMAL 8'h00
`define MODE_CALIBRATION 8'h01
`define MODE_DATA_WRITE 8'h04

`define BANK_CONTROL 8'h00
`define BANK_PROFILE_FIRST 8'h02
`define BANK_PROFILE_LAST 8'h03
`define BANK_MOTOR_FIRST 8'h04
`define BANK_MOTOR_LAST 8'h23
`define BANK_CUSTOMER_FIRST 8'h24
`define BANK_CUSTOMER_LAST 8'h43

`define CAL_CMD_CCW 8'h01
`define CAL_CMD_CW 8'h02
`define CAL_STAT_STOPPED 8'h00
`define CAL_STAT_RUNNING 8'h01
`define CAL_STAT_CCW_DONE 8'h02
`define CAL_STAT_CW_DONE 8'h22
`define CAL_STAT_WRONG_DIR 8'h30
`define CAL_STAT_TEMP 8'h31
`define CAL_STAT_SPEED 8'h32
`define CAL_STAT_FAIL 8'h33

`define DW_CMD_GRANT_MOTOR 8'h01
`define DW_CMD_GRANT_CUSTOMER 8'h02
`define DW_CMD_SAVE 8'h03
`define DW_CMD_REVOKE 8'h04
`define DW_STAT_WAIT_ACCESS 8'h00
`define DW_STAT_WAIT_SAVE 8'h01

`define CLK_HZ 20000000
`define CAL_TIME_MS 5000
`define CAL_CYCLES (`CAL_TIME_MS * (`CLK_HZ / 1000))

`endif

/* File: rtl/encoder_calib_pkg.sv */
// types shared by the command sequencer
`default_nettype none
package encoder_calib_pkg;
    typedef enum logic [1:0] {cal_idle, cal_run_ccw, cal_ccw_done, cal_run_cw} cal_phase_t;
    typedef enum logic [1:0] {grant_none, grant_motor, grant_customer} grant_t;
endpackage : encoder_calib_pkg
`default_nettype wire

/* File: rtl/encoder_calib_and_memory_write.sv */
// register-driven calibration and user data write sequencer with link-side access port
`timescale 1ns/1ps
`default_nettype none
`include "encoder_calib_regs.svh"

module encoder_calib_and_memory_write #(
    parameter int unsigned CAL_CYCLES = `CAL_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic link_clk_i,
    input wire logic link_req_i,
    input wire logic link_we_i,
    input wire logic [7:0] link_addr_i,
    input wire logic [7:0] link_wdata_i,
    input wire logic wrong_direction_i,
    input wire logic temp_out_of_range_i,
    input wire logic speed_out_of_range_i,
    input wire logic cal_failure_i,
    output logic link_busy_o,
    output logic link_ack_o,
    output logic [7:0] link_rdata_o,
    output logic cal_active_o,
    output logic cal_store_o,
    output logic cal_table_valid_o,
    output logic flash_commit_o,
    output encoder_calib_pkg::grant_t flash_region_o,
    output logic [7:0] device_mode_o
);
    import encoder_calib_pkg::*;

    localparam int MEM_WORDS = 4096;

    // link domain: reset sync, request capture, answer return
    logic link_rst_meta_q;
    logic link_rst_q;
    logic req_tgl_q;
    logic cap_we_q;
    logic [7:0] cap_addr_q;
    logic [7:0] cap_wdata_q;
    logic ack_meta_q;
    logic ack_sync_q;
    logic ack_seen_q;

    // core domain
    logic req_meta_q;
    logic req_sync_q;
    logic req_seen_q;
    logic ack_tgl_q;
    logic [7:0] core_rdata_q;
    logic unlocked_q;
    logic [7:0] mode_q;
    logic [7:0] bank_q;
    cal_phase_t cal_phase_q;
    logic [7:0] cal_status_q;
    logic [31:0] cal_count_q;
    grant_t grant_q;
    logic [7:0] mem_q [0:MEM_WORDS-1];

    logic req_pulse;
    logic wr;
    logic in_window;
    logic [5:0] page_addr;
    logic ctrl_bank;
    logic motor_bank;
    logic customer_bank;
    logic [7:0] bank_rel;
    logic [11:0] mem_index;
    logic cal_fault;
    logic [7:0] fault_code;
    logic [7:0] rd_value;

    always_ff @(posedge link_clk_i)
    begin
        link_rst_meta_q <= reset_i;
        link_rst_q <= link_rst_meta_q;
    end

    // answer toggle back into the link domain
    always_ff @(posedge link_clk_i)
    begin
        ack_meta_q <= ack_tgl_q;
        ack_sync_q <= ack_meta_q;
    end

    always_ff @(posedge link_clk_i)
    begin
        if (link_rst_q)
        begin
            req_tgl_q <= 1'b0;
            cap_we_q <= 1'b0;
            cap_addr_q <= 8'h00;
            cap_wdata_q <= 8'h00;
            link_busy_o <= 1'b0;
            link_ack_o <= 1'b0;
            link_rdata_o <= 8'h00;
            ack_seen_q <= 1'b0;
        end
        else
        begin
            link_ack_o <= 1'b0;
            // requests while busy are dropped; captured fields stay stable for the core
            if (link_req_i && !link_busy_o)
            begin
                cap_we_q <= link_we_i;
                cap_addr_q <= link_addr_i;
                cap_wdata_q <= link_wdata_i;
                req_tgl_q <= ~req_tgl_q;
                link_busy_o <= 1'b1;
            end
            else if (ack_sync_q != ack_seen_q)
            begin
                ack_seen_q <= ack_sync_q;
                link_busy_o <= 1'b0;
                link_ack_o <= 1'b1;
                link_rdata_o <= core_rdata_q;
            end
        end
    end

    // one toggle per request; captured fields held by busy until the answer
    always_ff @(posedge clk_i)
    begin
        req_meta_q <= req_tgl_q;
        req_sync_q <= req_meta_q;
    end

    assign req_pulse = req_sync_q != req_seen_q;
    assign wr = req_pulse && cap_we_q;
    assign in_window = cap_addr_q < `PAGED_WINDOW_LIMIT;
    assign page_addr = cap_addr_q[5:0];
    assign ctrl_bank = bank_q == `BANK_CONTROL;
    assign motor_bank = bank_q >= `BANK_MOTOR_FIRST && bank_q <= `BANK_MOTOR_LAST;
    assign customer_bank = bank_q >= `BANK_CUSTOMER_FIRST && bank_q <= `BANK_CUSTOMER_LAST;
    assign bank_rel = motor_bank ? bank_q - `BANK_MOTOR_FIRST : bank_q - `BANK_CUSTOMER_FIRST;
    assign mem_index = {customer_bank, bank_rel[4:0], page_addr};

    assign cal_fault = wrong_direction_i || temp_out_of_range_i || speed_out_of_range_i
        || cal_failure_i;

    always_comb
    begin
        // fixed priority when several faults rise together
        if (wrong_direction_i)
            fault_code = `CAL_STAT_WRONG_DIR;
        else if (temp_out_of_range_i)
            fault_code = `CAL_STAT_TEMP;
        else if (speed_out_of_range_i)
            fault_code = `CAL_STAT_SPEED;
        else
            fault_code = `CAL_STAT_FAIL;
    end

    // store reads see the array directly, so written bytes read back at once
    always_comb
    begin
        rd_value = 8'h00;
        if (in_window)
        begin
            if (ctrl_bank && page_addr == `CALIBRATION_STATUS_ADDR)
                rd_value = cal_status_q;
            else if (ctrl_bank && page_addr == `DATA_WRITE_STATUS_ADDR)
                rd_value = (grant_q == grant_none) ? `DW_STAT_WAIT_ACCESS
                    : `DW_STAT_WAIT_SAVE;
            else if (motor_bank || customer_bank)
                rd_value = mem_q[mem_index];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            req_seen_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            core_rdata_q <= 8'h00;
        end
        else if (req_pulse)
        begin
            req_seen_q <= req_sync_q;
            ack_tgl_q <= ~ack_tgl_q;
            core_rdata_q <= cap_we_q ? 8'h00 : rd_value;
        end
    end

    // direct registers: unlock, mode, bank
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            unlocked_q <= 1'b0;
            mode_q <= `MODE_NORMAL;
            bank_q <= `BANK_CONTROL;
        end
        else if (wr)
        begin
            if (cap_addr_q == `MODE_UNLOCK_PASSWORD_ADDR)
                unlocked_q <= cap_wdata_q == `UNLOCK_PASSWORD;
            else if (cap_addr_q == `DEVICE_MODE_ADDR)
            begin
                if (cap_wdata_q == `MODE_NORMAL)
                begin
                    mode_q <= `MODE_NORMAL;
                    unlocked_q <= 1'b0;
                end
                else if (unlocked_q && (cap_wdata_q == `MODE_CALIBRATION
                    || cap_wdata_q == `MODE_DATA_WRITE))
                    mode_q <= cap_wdata_q;
            end
            else if (cap_addr_q == `BANK_SELECT_ADDR)
                bank_q <= cap_wdata_q;
        end
    end

    // calibration sequencer; the pass counter ends each pass on its own
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cal_phase_q <= cal_idle;
            cal_status_q <= `CAL_STAT_STOPPED;
            cal_count_q <= 32'h0000_0000;
            cal_store_o <= 1'b0;
            cal_table_valid_o <= 1'b1;
        end
        else
        begin
            cal_store_o <= 1'b0;
            unique case (cal_phase_q)
                cal_idle, cal_ccw_done:
                begin
                    if (wr && in_window && ctrl_bank && page_addr == `CALIBRATION_COMMAND_ADDR
                        && mode_q == `MODE_CALIBRATION)
                    begin
                        if (cap_wdata_q == `CAL_CMD_CCW)
                        begin
                            cal_phase_q <= cal_run_ccw;
                            cal_status_q <= `CAL_STAT_RUNNING;
                            cal_count_q <= CAL_CYCLES - 1;
                        end
                        else if (cap_wdata_q == `CAL_CMD_CW && cal_phase_q == cal_ccw_done)
                        begin
                            cal_phase_q <= cal_run_cw;
                            cal_status_q <= `CAL_STAT_RUNNING;
                            cal_count_q <= CAL_CYCLES - 1;
                        end
                    end
                end
                cal_run_ccw:
                begin
                    // a fault in the last count cycle still wins
                    if (cal_fault)
                    begin
                        cal_phase_q <= cal_idle;
                        cal_status_q <= fault_code;
                    end
                    else if (cal_count_q == 32'h0000_0000)
                    begin
                        cal_phase_q <= cal_ccw_done;
                        cal_status_q <= `CAL_STAT_CCW_DONE;
                    end
                    else
                        cal_count_q <= cal_count_q - 1;
                end
                cal_run_cw:
                begin
                    if (cal_fault)
                    begin
                        cal_phase_q <= cal_idle;
                        cal_status_q <= fault_code;
                        cal_table_valid_o <= 1'b0;
                    end
                    else if (cal_count_q == 32'h0000_0000)
                    begin
                        cal_phase_q <= cal_idle;
                        cal_status_q <= `CAL_STAT_CW_DONE;
                        cal_store_o <= 1'b1;
                        cal_table_valid_o <= 1'b1;
                    end
                    else
                        cal_count_q <= cal_count_q - 1;
                end
            endcase
        end
    end

    // one cycle behind the phase, traded for a flopped output
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            cal_active_o <= 1'b0;
        else
            cal_active_o <= cal_phase_q == cal_run_ccw || cal_phase_q == cal_run_cw;
    end

    // data write access control
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            grant_q <= grant_none;
            flash_commit_o <= 1'b0;
            flash_region_o <= grant_none;
        end
        else
        begin
            flash_commit_o <= 1'b0;
            if (mode_q != `MODE_DATA_WRITE)
                grant_q <= grant_none; // leaving the mode drops any grant
            else if (wr && in_window && ctrl_bank && page_addr == `DATA_WRITE_COMMAND_ADDR)
            begin
                if (cap_wdata_q == `DW_CMD_GRANT_MOTOR && grant_q == grant_none)
                    grant_q <= grant_motor;
                else if (cap_wdata_q == `DW_CMD_GRANT_CUSTOMER && grant_q == grant_none)
                    grant_q <= grant_customer;
                else if (cap_wdata_q == `DW_CMD_SAVE && grant_q != grant_none)
                begin
                    flash_commit_o <= 1'b1;
                    flash_region_o <= grant_q;
                end
                else if (cap_wdata_q == `DW_CMD_REVOKE)
                    grant_q <= grant_none;
            end
        end
    end

    // store array; profile banks and control bank never reach it
    always_ff @(posedge clk_i)
    begin
        if (wr && in_window && unlocked_q && mode_q == `MODE_DATA_WRITE
            && ((motor_bank && grant_q == grant_motor)
            || (customer_bank && grant_q == grant_customer)))
            mem_q[mem_index] <= cap_wdata_q;
    end

    // registered copy so the mode output comes from a flip-flop
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            device_mode_o <= `MODE_NORMAL;
        else
            device_mode_o <= mode_q;
    end

endmodule : encoder_calib_and_memory_write

`default_nettype wire

/* File: tb/link_master_model.sv */
// link master model: free-running link clock and one register access at a time
`timescale 1ns/1ps
`default_nettype none
module link_master_model (
    output logic clk_o,
    output logic req_o,
    output logic we_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    input wire logic ack_i,
    input wire logic [7:0] rdata_i
);
    initial
    begin
        clk_o = 1'b0;
        req_o = 1'b0;
        we_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    always #15 clk_o = ~clk_o;
    // plain register access, next one only after the answer or after 40 silent cycles
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_o);
        req_o <= 1'b1;
        we_o <= w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_o);
        req_o <= 1'b0;
        // released lines show inverted values, never stale ones
        we_o <= ~w;
        addr_o <= ~a;
        wdata_o <= ~d;
        // silence is tolerated: give up after 40 cycles
        while (ack_i !== 1'b1 && n < 40)
        begin
            @(posedge clk_o);
            n++;
        end
        q = (n < 40) ? rdata_i : 8'hXX;
    endtask : access
endmodule : link_master_model
`default_nettype wire

/* File: tb/encoder_calib_and_memory_write_sva.sv */
// checker for the sequencer's link handshake, calibration and commit outputs
`timescale 1ns/1ps
`default_nettype none
module encoder_calib_and_memory_write_sva
    import encoder_calib_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = 50
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic link_clk_i,
    input wire logic link_req_i,
    input wire logic link_busy_o,
    input wire logic link_ack_o,
    input wire logic cal_active_o,
    input wire logic cal_store_o,
    input wire logic cal_table_valid_o,
    input wire logic flash_commit_o,
    input wire grant_t flash_region_o,
    input wire logic [7:0] device_mode_o
);
    int unsigned run_q;
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !cal_active_o)
            run_q <= 0;
        else
            run_q <= run_q + 1;
    end
    property p_take;
        @(posedge link_clk_i) disable iff (reset_i)
        link_req_i && !link_busy_o |=> link_busy_o;
    endproperty
    a_take: assert property (p_take)
        else $error("request not taken");
    property p_answer;
        @(posedge link_clk_i) disable iff (reset_i)
        $rose(link_busy_o) |-> link_busy_o[*3] ##[1:12] link_ack_o;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no answer in time");
    property p_ack_pulse;
        @(posedge link_clk_i) disable iff (reset_i)
        link_ack_o |=> !link_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("answer longer than one cycle");
    property p_store;
        @(posedge clk_i) disable iff (reset_i)
        cal_store_o |=> !cal_store_o && cal_table_valid_o;
    endproperty
    a_store: assert property (p_store)
        else $error("table store pulse wrong");
    property p_commit;
        @(posedge clk_i) disable iff (reset_i)
        flash_commit_o |-> device_mode_o == 8'h04 ##1 !flash_commit_o
            && flash_region_o != grant_none;
    endproperty
    a_commit: assert property (p_commit)
        else $error("commit outside data write mode");
    property p_cal_mode;
        @(posedge clk_i) disable iff (reset_i)
        $rose(cal_active_o) |-> device_mode_o == 8'h01;
    endproperty
    a_cal_mode: assert property (p_cal_mode)
        else $error("pass started outside calibration mode");
    property p_valid_drop;
        @(posedge clk_i) disable iff (reset_i)
        $fell(cal_table_valid_o) |-> device_mode_o == 8'h01;
    endproperty
    a_valid_drop: assert property (p_valid_drop)
        else $error("table dropped outside calibration");
    property p_run_len;
        @(posedge clk_i) disable iff (reset_i)
        run_q <= CAL_CYCLES + 4;
    endproperty
    a_run_len: assert property (p_run_len)
        else $error("pass does not end by itself");
endmodule : encoder_calib_and_memory_write_sva
bind encoder_calib_and_memory_write encoder_calib_and_memory_write_sva #(
    .CAL_CYCLES(CAL_CYCLES)
) i_sva (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .link_clk_i(link_clk_i),
    .link_req_i(link_req_i),
    .link_busy_o(link_busy_o),
    .link_ack_o(link_ack_o),
    .cal_active_o(cal_active_o),
    .cal_store_o(cal_store_o),
    .cal_table_valid_o(cal_table_valid_o),
    .flash_commit_o(flash_commit_o),
    .flash_region_o(flash_region_o),
    .device_mode_o(device_mode_o)
);
`default_nettype wire

/* File: tb/encoder_calib_and_memory_write_test.sv */
// self-checking bench: calibration passes, faults and user data writes
`timescale 1ns/1ps
`default_nettype none
module encoder_calib_and_memory_write_test;
    import encoder_calib_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] fault_q = 4'h0;
    logic lclk, req, we, busy, ack, active, store, valid, commit;
    logic [7:0] addr, wdata, rdata, mode;
    grant_t region;
    int failures = 0;
    int n_compared = 0;
    int stores = 0;
    int commits = 0;
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        stores <= stores + int'(store);
        commits <= commits + int'(commit);
    end
    encoder_calib_and_memory_write #(
        .CAL_CYCLES(50)
    ) i_dut (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .link_clk_i(lclk),
        .link_req_i(req),
        .link_we_i(we),
        .link_addr_i(addr),
        .link_wdata_i(wdata),
        .wrong_direction_i(fault_q[0]),
        .temp_out_of_range_i(fault_q[1]),
        .speed_out_of_range_i(fault_q[2]),
        .cal_failure_i(fault_q[3]),
        .link_busy_o(busy),
        .link_ack_o(ack),
        .link_rdata_o(rdata),
        .cal_active_o(active),
        .cal_store_o(store),
        .cal_table_valid_o(valid),
        .flash_commit_o(commit),
        .flash_region_o(region),
        .device_mode_o(mode)
    );
    link_master_model i_master (
        .clk_o(lclk),
        .req_o(req),
        .we_o(we),
        .addr_o(addr),
        .wdata_o(wdata),
        .ack_i(ack),
        .rdata_i(rdata)
    );
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_master.access(1'b1, a, d, q);
        check("write answer", q, 8'h00);
    endtask : wr
    task automatic rc(input string what, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        i_master.access(1'b0, a, 8'h00, q);
        check(what, q, e);
    endtask : rc
    // only status is read while a pass runs, never position
    task automatic poll(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        q = ~e;
        for (int n = 0; n < 30 && q !== e; n++)
            i_master.access(1'b0, a, 8'h00, q);
        check("polled status", q, e);
    endtask : poll
    task automatic flt(input logic [3:0] f);
        @(posedge clk_i);
        fault_q <= f;
    endtask : flt
    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    // some twenty times the expected run length
    initial
    begin
        #500us;
        failures++;
        end_sim();
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        wr(8'h6A, 8'h01);
        check("mode", mode, 8'h00);
        wr(8'h6B, 8'h2A);
        wr(8'h6A, 8'h01);
        check("mode", mode, 8'h01);
        wr(8'h40, 8'h00);
        wr(8'h00, 8'h02);
        rc("early cw", 8'h01, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h00, 8'h01);
            rc("running", 8'h01, 8'h01);
            check("active", {7'h00, active}, 8'h01);
            flt(4'h1 << i);
            poll(8'h01, 8'h30 + 8'(i));
            flt(4'h0);
        end
        wr(8'h00, 8'h01);
        poll(8'h01, 8'h02);
        wr(8'h00, 8'h02);
        poll(8'h01, 8'h22);
        check("stores", 8'(stores), 8'h01);
        wr(8'h00, 8'h01);
        poll(8'h01, 8'h02);
        wr(8'h00, 8'h02);
        flt(4'h8);
        poll(8'h01, 8'h33);
        check("table", {7'h00, valid}, 8'h00);
        flt(4'h0);
        wr(8'h6A, 8'h00);
        check("mode", mode, 8'h00);
        wr(8'h00, 8'h01);
        rc("normal cmd", 8'h01, 8'h33);
        $display("calibration test done");
        wr(8'h6A, 8'h04);
        check("mode", mode, 8'h00);
        wr(8'h6B, 8'h2A);
        wr(8'h6A, 8'h04);
        check("mode", mode, 8'h04);
        wr(8'h40, 8'h00);
        rc("dw idle", 8'h1B, 8'h00);
        wr(8'h1A, 8'h01);
        poll(8'h1B, 8'h01);
        check("motor idle", {7'h00, active}, 8'h00);
        wr(8'h40, 8'h04);
        wr(8'h05, 8'hA5);
        rc("motor byte", 8'h05, 8'hA5);
        wr(8'h40, 8'h02);
        wr(8'h05, 8'h66);
        rc("profile", 8'h05, 8'h00);
        wr(8'h40, 8'h00);
        wr(8'h1A, 8'h03);
        check("commits", 8'(commits), 8'h01);
        check("region", 8'(region), 8'(grant_motor));
        wr(8'h1A, 8'h04);
        rc("revoked", 8'h1B, 8'h00);
        wr(8'h1A, 8'h03);
        check("no save", 8'(commits), 8'h01);
        wr(8'h40, 8'h04);
        wr(8'h05, 8'h11);
        rc("no grant", 8'h05, 8'hA5);
        wr(8'h40, 8'h00);
        wr(8'h1A, 8'h02);
        poll(8'h1B, 8'h01);
        wr(8'h40, 8'h43);
        wr(8'h3F, 8'h5A);
        rc("customer byte", 8'h3F, 8'h5A);
        wr(8'h40, 8'h00);
        wr(8'h1A, 8'h03);
        check("region", 8'(region), 8'(grant_customer));
        wr(8'h6A, 8'h00);
        rc("unmapped", 8'h50, 8'h00);
        $display("data write test done");
        end_sim();
    end
endmodule : encoder_calib_and_memory_write_test
`default_nettype wire
